// ===== pse_panel.sv
// Front-panel status, error lamps, display and selector decode
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pse_panel
  import pse_pkg::*;
#(
  parameter logic [35:0] PROTECT_CYC = PROTECT_CYC_DEF,
  parameter logic [35:0] FAULT_CYC   = FAULT_CYC_DEF,
  parameter logic [35:0] FLASH_CYC   = FLASH_CYC_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_init,
  input  wire logic [2:0]  sel_mode,
  input  wire logic [2:0]  sel_class,
  input  wire logic        fd_protect_sw,
  input  wire logic        hd_protect_sw,
  input  wire logic        fd_media_wp,
  input  wire logic        fd_head_loaded,
  input  wire logic        hd_drive_fault,
  input  wire logic        hd_access,
  output var  logic        st_start,
  output var  logic [1:0]  st_index,
  input  wire logic        st_done,
  input  wire logic        st_fail,
  output var  logic        home_req,
  input  wire logic        home_fd_done,
  input  wire logic        home_hd_done,
  output var  logic        hd_wr_protect,
  output var  logic        lamp_hd_ready,
  output var  logic        lamp_fd_act,
  output var  logic        fd_door_lock,
  output var  logic        lamp_fd_wp,
  output var  logic        lamp_hd_wp,
  output var  logic        lamp_fault,
  output var  logic        lamp_fd_err,
  output var  logic        lamp_hd_err,
  output var  logic [7:0]  disp_code,
  output var  logic        disp_lit,
  output var  logic [1:0]  hd_personality,
  output var  logic [7:0]  hd_capacity,
  output var  logic        fd_format,
  output var  logic        fd_set_density,
  output var  logic        fd_double,
  output var  logic        fd_scan
);

  // Synchronised pins
  logic        init_s;
  logic [2:0]  mode_s;
  logic [2:0]  class_s;
  logic        fd_sw_s;
  logic        hd_sw_s;
  logic        fd_wp_s;
  logic        head_s;
  logic        fault_s;

  pse_sync #(.W(12)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({hd_drive_fault, fd_head_loaded, fd_media_wp, hd_protect_sw, fd_protect_sw,
               sel_class, sel_mode, bus_init}),
    .sync    ({fault_s, head_s, fd_wp_s, hd_sw_s, fd_sw_s, class_s, mode_s, init_s})
  );

  // Blink combiner used by every flashing lamp
  function automatic logic lamp_drive(input logic on, input logic flash, input logic phase);
    lamp_drive = on & (~flash | phase);
  endfunction

  // State
  pse_state_e  state_q;
  pse_state_e  state_d;
  logic [1:0]  st_idx_q;
  logic [35:0] prot_cnt_q;
  logic [35:0] fault_tmr_q;
  logic [35:0] blink_cnt_q;
  logic        blink_q;
  logic        fd_hm_q;
  logic        hd_hm_q;
  logic        map_ok_q;
  logic        diag_q;
  logic [7:0]  diag_code_q;
  logic        pend_fd_q;
  logic        pend_hd_q;
  logic [7:0]  code_fd_q;
  logic [7:0]  code_hd_q;
  logic        last_hd_q;
  logic [7:0]  last_err_q;
  logic        last_err_hd_q;

  // APB decode
  wire setup_ph  = psel & ~penable;
  wire acc_ph    = psel & penable;
  wire hit_ctrl  = (paddr == REG_CTRL);
  wire hit_err   = (paddr == REG_ERR);
  wire hit_clr   = (paddr == REG_CLR);
  wire hit_stat  = (paddr == REG_STAT);
  wire mapped    = hit_ctrl | hit_err | hit_clr | hit_stat;
  wire wr_en     = acc_ph & pwrite & mapped;
  wire err_we    = wr_en & hit_err;
  wire err_is_hd = pwdata[ERR_DRIVE_HD];
  wire clr_fd    = wr_en & hit_clr & pwdata[CLR_FD];
  wire clr_hd    = wr_en & hit_clr & pwdata[CLR_HD];
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~mapped;

  // Error bookkeeping: report wins over clear in the same cycle
  wire set_fd    = err_we & ~err_is_hd;
  wire set_hd    = err_we & err_is_hd;
  wire pend_fd_d = set_fd | (pend_fd_q & ~clr_fd & ~init_s);
  wire pend_hd_d = set_hd | (pend_hd_q & ~clr_hd & ~init_s);
  wire pend_any  = pend_fd_q | pend_hd_q;
  wire recent_hd = pend_hd_q & (last_hd_q | ~pend_fd_q);
  wire prot_on   = (prot_cnt_q != CNT_ZERO);
  wire fault_fl  = (fault_tmr_q != CNT_ZERO);

  // Power-up sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PS_TEST: state_d = PS_WAIT;
      PS_WAIT: begin
        if (st_done && st_fail) begin
          state_d = PS_FAIL;
        end else if (st_done && st_idx_q == ST_LAST) begin
          state_d = PS_HOME;
        end else if (st_done) begin
          state_d = PS_TEST;
        end
      end
      PS_HOME: begin
        if (fd_hm_q && hd_hm_q) begin
          state_d = PS_RUN;
        end
      end
      PS_RUN:  state_d = PS_RUN;
      PS_FAIL: state_d = PS_FAIL;
    endcase
  end

  // Sequencer registers and test strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= PS_TEST;
      st_idx_q <= 2'h0;
      st_start <= 1'b0;
      home_req <= 1'b0;
    end else begin
      state_q  <= state_d;
      st_start <= (state_q == PS_TEST);
      home_req <= (state_q == PS_WAIT) && (state_d == PS_HOME);
      if (state_q == PS_WAIT && state_d == PS_TEST) begin
        st_idx_q <= st_idx_q + 2'h1;
      end
    end
  end
  assign st_index = st_idx_q;

  // Homing completion flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fd_hm_q <= 1'b0;
      hd_hm_q <= 1'b0;
    end else begin
      fd_hm_q <= (state_q == PS_HOME) & (fd_hm_q | home_fd_done);
      hd_hm_q <= (state_q == PS_HOME) & (hd_hm_q | home_hd_done);
    end
  end

  // Minute-scale timers and flash phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_cnt_q  <= PROTECT_CYC;
      fault_tmr_q <= CNT_ZERO;
      blink_cnt_q <= CNT_ZERO;
      blink_q     <= 1'b0;
    end else begin
      if (prot_on) begin
        prot_cnt_q <= prot_cnt_q - CNT_ONE;
      end
      if (err_we) begin
        fault_tmr_q <= FAULT_CYC;
      end else if (init_s) begin
        fault_tmr_q <= CNT_ZERO;
      end else if (fault_fl) begin
        fault_tmr_q <= fault_tmr_q - CNT_ONE;
      end
      if (init_s || blink_cnt_q == FLASH_CYC - CNT_ONE) begin
        blink_cnt_q <= CNT_ZERO;
        blink_q     <= ~blink_q & ~init_s;
      end else begin
        blink_cnt_q <= blink_cnt_q + CNT_ONE;
      end
    end
  end

  // Pending errors and their order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_fd_q     <= 1'b0;
      pend_hd_q     <= 1'b0;
      code_fd_q     <= CODE_NONE;
      code_hd_q     <= CODE_NONE;
      last_hd_q     <= 1'b0;
      last_err_q    <= CODE_NONE;
      last_err_hd_q <= 1'b0;
    end else begin
      pend_fd_q <= pend_fd_d;
      pend_hd_q <= pend_hd_d;
      if (set_fd) begin
        code_fd_q <= pwdata[7:0];
      end
      if (set_hd) begin
        code_hd_q <= pwdata[7:0];
      end
      if (err_we) begin
        last_hd_q     <= err_is_hd;
        last_err_q    <= pwdata[7:0];
        last_err_hd_q <= err_is_hd;
      end else if (pend_fd_d != pend_hd_d) begin
        last_hd_q <= pend_hd_d;
      end
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ok_q    <= 1'b0;
      diag_q      <= 1'b0;
      diag_code_q <= CODE_NONE;
    end else if (wr_en && hit_ctrl) begin
      map_ok_q    <= pwdata[CTRL_MAP_OK];
      diag_q      <= pwdata[CTRL_DIAG];
      diag_code_q <= pwdata[CTRL_CODE_LO +: 8];
    end
  end

  // Display and lamp selection
  wire [7:0] st_code = CODE_ST_BASE + {6'h00, st_idx_q};
  wire [7:0] err_code = recent_hd ? code_hd_q : code_fd_q;
  wire [7:0] disp_d = (state_q == PS_FAIL) ? st_code :
                      pend_any ? err_code :
                      diag_q ? diag_code_q :
                      CODE_NONE;
  wire disp_fl   = (state_q == PS_FAIL) | pend_any;
  wire ready_d   = ~fault_s & (prot_on | (map_ok_q & ~hd_access));
  wire fault_on  = pend_any & ~init_s;
  wire fd_err_fl = pend_fd_q & ~recent_hd;
  wire hd_err_fl = recent_hd;

  // Registered panel outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hd_wr_protect <= 1'b1;
      lamp_hd_ready <= 1'b0;
      lamp_fd_act   <= 1'b0;
      fd_door_lock  <= 1'b0;
      lamp_fd_wp    <= 1'b0;
      lamp_hd_wp    <= 1'b0;
      lamp_fault    <= 1'b0;
      lamp_fd_err   <= 1'b0;
      lamp_hd_err   <= 1'b0;
      disp_code     <= CODE_NONE;
      disp_lit      <= 1'b1;
    end else begin
      hd_wr_protect <= prot_on | hd_sw_s;
      lamp_hd_ready <= lamp_drive(ready_d, prot_on, blink_q);
      lamp_fd_act   <= head_s;
      fd_door_lock  <= head_s;
      lamp_fd_wp    <= fd_sw_s | fd_wp_s;
      lamp_hd_wp    <= hd_sw_s;
      lamp_fault    <= lamp_drive(fault_on, fault_fl, blink_q);
      lamp_fd_err   <= lamp_drive(pend_fd_q, fd_err_fl, blink_q);
      lamp_hd_err   <= lamp_drive(pend_hd_q, hd_err_fl, blink_q);
      disp_code     <= disp_d;
      disp_lit      <= lamp_drive(1'b1, disp_fl, blink_q);
    end
  end

  // Selector decode
  wire is_fixed  = (mode_s == MODE_FIXED);
  wire is_floppy = (mode_s == MODE_FLOPPY);
  wire [1:0] pers_d = ~is_fixed ? PERS_NONE :
                      (class_s == CLS_0) ? PERS_NORMAL :
                      (class_s == CLS_1) ? PERS_EXTENDED :
                      (class_s == CLS_2) ? PERS_DIRECT : PERS_NONE;
  wire [7:0] cap_d = (pers_d == PERS_NORMAL) ? CAP_NORMAL_TENTHS :
                     (pers_d == PERS_EXTENDED) ? CAP_EXTENDED_TENTHS : CODE_NONE;
  wire fmt_d  = is_floppy & (class_s == CLS_0 || class_s == CLS_1);
  wire sden_d = is_floppy & (class_s == CLS_2 || class_s == CLS_3 ||
                             class_s == CLS_4 || class_s == CLS_5);
  wire dbl_d  = is_floppy & (class_s == CLS_0 || class_s == CLS_2 || class_s == CLS_4);
  wire scan_d = is_floppy & (class_s == CLS_4 || class_s == CLS_5);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hd_personality <= PERS_NONE;
      hd_capacity    <= CODE_NONE;
      fd_format      <= 1'b0;
      fd_set_density <= 1'b0;
      fd_double      <= 1'b0;
      fd_scan        <= 1'b0;
    end else begin
      hd_personality <= pers_d;
      hd_capacity    <= cap_d;
      fd_format      <= fmt_d;
      fd_set_density <= sden_d;
      fd_double      <= dbl_d;
      fd_scan        <= scan_d;
    end
  end

  // Read data captured in the setup phase
  wire [31:0] stat_word = {10'h000, class_s, mode_s, disp_code, fault_fl, last_hd_q,
                           pend_hd_q, pend_fd_q, prot_on, state_q};
  wire [31:0] rd_d = hit_ctrl ? {16'h0000, diag_code_q, 6'h00, diag_q, map_ok_q} :
                     hit_err  ? {23'h000000, last_err_hd_q, last_err_q} :
                     hit_stat ? stat_word : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h00000000 : rd_d;
    end
  end

  // Checks
  sequence s_test_pass;
    st_done && !st_fail && st_idx_q == ST_LAST && state_q == PS_WAIT;
  endsequence
  sequence s_home_pulse;
    home_req ##1 !home_req;
  endsequence

  a_selftest_fail: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == PS_WAIT && st_done && st_fail) |=> ##1 (disp_code == CODE_ST_BASE + {6'h00, st_idx_q}))
    else $error("failing self-test code not shown");
  a_home_after_pass: assert property (@(posedge pclk) disable iff (!presetn)
    s_test_pass |=> s_home_pulse)
    else $error("homing not requested after self-tests");
  a_protect_window: assert property (@(posedge pclk) disable iff (!presetn)
    prot_on |=> hd_wr_protect)
    else $error("fixed disk not protected in window");
  a_ready_fault: assert property (@(posedge pclk) disable iff (!presetn)
    fault_s |=> !lamp_hd_ready)
    else $error("ready lamp lit during drive fault");
  a_ready_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (hd_access && !prot_on) |=> !lamp_hd_ready)
    else $error("ready lamp lit during access");
  a_door_head: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(head_s) |=> (lamp_fd_act && fd_door_lock))
    else $error("activity lamp or lock missed head load");
  a_fd_protect: assert property (@(posedge pclk) disable iff (!presetn)
    (fd_sw_s || fd_wp_s) |=> lamp_fd_wp)
    else $error("floppy protect lamp off");
  a_fault_restart: assert property (@(posedge pclk) disable iff (!presetn)
    err_we |=> (fault_tmr_q == FAULT_CYC))
    else $error("fault flash period not restarted");
  a_init_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (init_s && !err_we) |=> (!pend_fd_q && !pend_hd_q) ##1 !lamp_fault)
    else $error("bus initialize did not clear errors");
  a_display_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == PS_RUN && !pend_any && !diag_q) |=> (disp_code == CODE_NONE))
    else $error("idle display not 00");
  a_recent_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_fd_q && pend_hd_q && last_hd_q && clr_hd && !clr_fd && !err_we && !init_s) |=> !recent_hd ##1
    (disp_code == code_fd_q))
    else $error("display did not move to other drive");

endmodule
`default_nettype wire

// ===== pse_pkg.sv
// Constants, types and register map of the panel status and error indicator
// Contract
// - Run four power-on self-tests, show failing code
// - All tests pass: home floppy and fixed disk
// - Fixed disk write protected two minutes after power-on
// - Ready lamp flashes in window, then steady
// - Fixed-disk access flickers ready lamp off; in the protect window the code ignores access and keeps it flashing
// - Drive fault keeps ready lamp off
// - Activity lamp and door lock follow head load
// - Floppy protect lamp: switch or protected diskette
// - Fixed protect lamp follows panel switch
// - Fault lamp flashes one minute, then steady
// - New error restarts one-minute flashing period
// - Bus initialize turns fault lamp off
// - Error lamp of displayed drive flashes
// - Display flashes most recent error code
// - No pending error shows code 00
// - Bus initialize clears every pending error
// - Diagnostic shows test code until done or fail
// - Earlier drive error lamp steady, recent flashes
// - Clearing recent error shows other drive's error
// - Mode 0 selects fixed-disk personality by class
// - Mode 1 selects floppy format and density functions
package pse_pkg;

  // Clock and timing
  localparam longint unsigned CLK_HZ      = 250_000_000;
  localparam longint unsigned PROTECT_S   = 120;
  localparam longint unsigned FAULT_S     = 60;
  localparam longint unsigned FLASH_MS    = 250;
  localparam logic [35:0]     PROTECT_CYC_DEF = 36'(PROTECT_S * CLK_HZ);
  localparam logic [35:0]     FAULT_CYC_DEF   = 36'(FAULT_S * CLK_HZ);
  localparam logic [35:0]     FLASH_CYC_DEF   = 36'(FLASH_MS * (CLK_HZ / 1000));

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ERR  = 8'h04;
  localparam logic [7:0] REG_CLR  = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;

  // Field positions
  localparam int CTRL_MAP_OK   = 0;
  localparam int CTRL_DIAG     = 1;
  localparam int CTRL_CODE_LO  = 8;
  localparam int ERR_DRIVE_HD  = 8;
  localparam int CLR_FD        = 0;
  localparam int CLR_HD        = 1;

  // Codes
  localparam logic [7:0]  CODE_NONE   = 8'h00;
  localparam logic [7:0]  CODE_ST_BASE = 8'h10;
  localparam logic [1:0]  ST_LAST     = 2'h3;
  localparam logic [35:0] CNT_ZERO    = 36'h0;
  localparam logic [35:0] CNT_ONE     = 36'h1;

  // Selector modes and classes
  localparam logic [2:0] MODE_FIXED  = 3'h0;
  localparam logic [2:0] MODE_FLOPPY = 3'h1;
  localparam logic [2:0] CLS_0 = 3'h0;
  localparam logic [2:0] CLS_1 = 3'h1;
  localparam logic [2:0] CLS_2 = 3'h2;
  localparam logic [2:0] CLS_3 = 3'h3;
  localparam logic [2:0] CLS_4 = 3'h4;
  localparam logic [2:0] CLS_5 = 3'h5;

  // Fixed-disk capacity in tenths of a Mbyte per personality
  localparam logic [7:0] CAP_NORMAL_TENTHS   = 8'h35;
  localparam logic [7:0] CAP_EXTENDED_TENTHS = 8'h4e;

  // Fixed-disk personalities
  localparam logic [1:0] PERS_NONE     = 2'h0;
  localparam logic [1:0] PERS_NORMAL   = 2'h1;
  localparam logic [1:0] PERS_EXTENDED = 2'h2;
  localparam logic [1:0] PERS_DIRECT   = 2'h3;

  // Power-up sequence
  typedef enum logic [2:0] {
    PS_TEST,
    PS_WAIT,
    PS_HOME,
    PS_RUN,
    PS_FAIL
  } pse_state_e;

endpackage

// ===== pse_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pse_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] sync
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // First stage feeds only the second; output moves when stages 2 and 3 agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q    <= 1'b0;
          s2_q    <= 1'b0;
          s3_q    <= 1'b0;
          sync[i] <= 1'b0;
        end else begin
          s1_q <= pin[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            sync[i] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== pse_test_model.sv
// Self-test and drive homing responder standing in for the far side
`timescale 1ns/100ps
`default_nettype none
module pse_test_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       st_start,
  input  wire logic [1:0] st_index,
  input  wire logic [2:0] fail_at,
  input  wire logic       home_req,
  output var  logic       st_done,
  output var  logic       st_fail,
  output var  logic       home_fd_done,
  output var  logic       home_hd_done
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic [3:0] hcnt_q;
  // Odd tests answer slowly, even ones at once; fail flag is junk outside done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q       <= 1'b0;
      cnt_q        <= 4'h0;
      hcnt_q       <= 4'h0;
      st_done      <= 1'b0;
      st_fail      <= 1'b0;
      home_fd_done <= 1'b0;
      home_hd_done <= 1'b0;
    end else begin
      st_done      <= 1'b0;
      st_fail      <= ~st_fail;
      home_fd_done <= (hcnt_q == 4'h3);
      home_hd_done <= (hcnt_q == 4'h7);
      if (home_req) begin
        hcnt_q <= 4'h1;
      end else if (hcnt_q != 4'h0 && hcnt_q != 4'h8) begin
        hcnt_q <= hcnt_q + 4'h1;
      end
      if (st_start) begin
        busy_q <= 1'b1;
        cnt_q  <= st_index[0] ? 4'h6 : 4'h0;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q  <= 1'b0;
        st_done <= 1'b1;
        st_fail <= ({1'b0, st_index} == fail_at);
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the panel status and error indicator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pse_pkg::*;
  localparam logic [35:0] PROT = 36'hc8;
  localparam logic [35:0] FLT  = 36'h64;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_init, er;
  logic        fd_protect_sw, hd_protect_sw, fd_media_wp, fd_head_loaded, hd_drive_fault, hd_access;
  logic        st_start, st_done, st_fail, home_req, home_fd_done, home_hd_done, hd_wr_protect;
  logic        lamp_hd_ready, lamp_fd_act, fd_door_lock, lamp_fd_wp, lamp_hd_wp, lamp_fault;
  logic        lamp_fd_err, lamp_hd_err, disp_lit, fd_format, fd_set_density, fd_double, fd_scan;
  logic [1:0]  st_index, hd_personality;
  logic [2:0]  sel_mode, sel_class, fail_at;
  logic [7:0]  paddr, disp_code, hd_capacity;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt, checks, cyc, rel_cyc, n_st, n_home, k;
  wire logic [8:0] lamps;
  // Lamp index: 0 ready,1 act,2 door,3 fd wp,4 hd wp,5 fault,6 fd err,7 hd err,8 display
  assign lamps = {disp_lit, lamp_hd_err, lamp_fd_err, lamp_fault, lamp_hd_wp, lamp_fd_wp, fd_door_lock,
                  lamp_fd_act, lamp_hd_ready};

  pse_panel #(.PROTECT_CYC(PROT), .FAULT_CYC(FLT), .FLASH_CYC(36'h4)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_init,
    .sel_mode, .sel_class, .fd_protect_sw, .hd_protect_sw, .fd_media_wp, .fd_head_loaded, .hd_drive_fault,
    .hd_access, .st_start, .st_index, .st_done, .st_fail, .home_req, .home_fd_done, .home_hd_done,
    .hd_wr_protect, .lamp_hd_ready, .lamp_fd_act, .fd_door_lock, .lamp_fd_wp, .lamp_hd_wp, .lamp_fault,
    .lamp_fd_err, .lamp_hd_err, .disp_code, .disp_lit, .hd_personality, .hd_capacity, .fd_format,
    .fd_set_density, .fd_double, .fd_scan);
  pse_test_model PTR (.pclk, .presetn, .st_start, .st_index, .fail_at, .home_req, .st_done, .st_fail,
    .home_fd_done, .home_hd_done);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Pulse counters and hang limit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_st <= 0;
      n_home <= 0;
    end else begin
      n_st <= n_st + int'(st_start === 1'b1);
      n_home <= n_home + int'(home_req === 1'b1);
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Settle, then watch a lamp: 0 off, 1 steady, 2 flashing, 3 unknown
  task automatic lamp(input string nm, input int i, input logic [1:0] exp);
    int on;
    int off;
    on = 0;
    off = 0;
    repeat (8) @(posedge pclk);
    repeat (16) begin
      @(posedge pclk);
      on += int'(lamps[i] === 1'b1);
      off += int'(lamps[i] === 1'b0);
    end
    chk(nm, 32'(exp), (on == 16) ? 1 : (off == 16) ? 0 : (on + off == 16) ? 2 : 3);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reset_dut(input logic [2:0] f);
    fail_at <= f;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rel_cyc = cyc;
  endtask

  task automatic t_fail;
    reset_dut(3'h2);
    for (k = 0; k < 300 && disp_code !== CODE_ST_BASE + 8'h2; k++) @(posedge pclk);
    chk("fail code", 32'(CODE_ST_BASE + 8'h2), 32'(disp_code));
    chk("tests run", 3, n_st);
    chk("homes", 0, n_home);
    apb(1'b0, REG_STAT, 32'h0);
    chk("state", 32'(PS_FAIL), 32'(rd[2:0]));
    $display("test fail done");
  endtask

  task automatic t_power;
    reset_dut(3'h4);
    for (k = 0; k < 300 && n_home == 0; k++) @(posedge pclk);
    repeat (12) @(posedge pclk);
    chk("tests run", 4, n_st);
    chk("homes", 1, n_home);
    apb(1'b0, REG_STAT, 32'h0);
    chk("state", 32'(PS_RUN), 32'(rd[2:0]));
    apb(1'b1, REG_CTRL, 32'h1);
    chk("protect", 1, 32'(hd_wr_protect));
    lamp("ready", 0, 2'h2);
    for (k = 0; k < 400 && hd_wr_protect !== 1'b0; k++) @(posedge pclk);
    chk("window", 1, 32'(cyc - rel_cyc >= int'(PROT) && cyc - rel_cyc <= int'(PROT) + 6));
    lamp("ready", 0, 2'h1);
    $display("test power done");
  endtask

  task automatic t_pins;
    fd_protect_sw <= 1'b1;
    lamp("fd wp sw", 3, 2'h1);
    fd_protect_sw <= 1'b0;
    fd_media_wp <= 1'b1;
    lamp("fd wp media", 3, 2'h1);
    fd_media_wp <= 1'b0;
    hd_protect_sw <= 1'b1;
    lamp("fd wp off", 3, 2'h0);
    lamp("hd wp", 4, 2'h1);
    hd_protect_sw <= 1'b0;
    fd_head_loaded <= 1'b1;
    lamp("act", 1, 2'h1);
    lamp("door", 2, 2'h1);
    fd_head_loaded <= 1'b0;
    hd_access <= 1'b1;
    lamp("door off", 2, 2'h0);
    lamp("busy", 0, 2'h0);
    hd_access <= 1'b0;
    hd_drive_fault <= 1'b1;
    lamp("drv fault", 0, 2'h0);
    hd_drive_fault <= 1'b0;
    lamp("ready back", 0, 2'h1);
    $display("test pins done");
  endtask

  task automatic t_err;
    apb(1'b1, REG_ERR, 32'h21);
    lamp("fault", 5, 2'h2);
    lamp("fd err", 6, 2'h2);
    chk("code", 32'h21, 32'(disp_code));
    lamp("disp flash", 8, 2'h2);
    apb(1'b1, REG_ERR, 32'h35 | (32'h1 << ERR_DRIVE_HD));
    lamp("hd err", 7, 2'h2);
    lamp("fd earlier", 6, 2'h1);
    chk("code", 32'h35, 32'(disp_code));
    apb(1'b0, REG_ERR, 32'h0);
    chk("err rd", 32'h135, rd);
    repeat (int'(FLT) + 10) @(posedge pclk);
    lamp("fault on", 5, 2'h1);
    apb(1'b1, REG_ERR, 32'h22);
    lamp("fault again", 5, 2'h2);
    apb(1'b1, REG_CLR, 32'h1 << CLR_FD);
    lamp("hd shown", 7, 2'h2);
    chk("code", 32'h35, 32'(disp_code));
    apb(1'b1, REG_CLR, 32'h1 << CLR_HD);
    lamp("fault off", 5, 2'h0);
    chk("code", 32'(CODE_NONE), 32'(disp_code));
    apb(1'b1, REG_ERR, 32'h44);
    apb(1'b1, REG_ERR, 32'h66 | (32'h1 << ERR_DRIVE_HD));
    apb(1'b1, REG_CLR, 32'h1 << CLR_HD);
    repeat (3) @(posedge pclk);
    chk("code", 32'h44, 32'(disp_code));
    bus_init <= 1'b1;
    repeat (2) @(posedge pclk);
    bus_init <= 1'b0;
    lamp("init fault", 5, 2'h0);
    lamp("init err", 6, 2'h0);
    chk("code", 32'(CODE_NONE), 32'(disp_code));
    $display("test errors done");
  endtask

  task automatic t_misc;
    apb(1'b1, REG_CTRL, 32'h4203);
    lamp("diag lit", 8, 2'h1);
    chk("diag", 32'h42, 32'(disp_code));
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("diag end", 32'(CODE_NONE), 32'(disp_code));
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, REG_STAT, 32'hffffffff);
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat ro", 32'(PS_RUN), 32'(rd[2:0]));
    for (int c = 0; c < 6; c++) begin
      sel_mode <= (c < 3) ? MODE_FIXED : MODE_FLOPPY;
      sel_class <= 3'(c % 3);
      repeat (8) @(posedge pclk);
      chk("pers", (c < 3) ? 32'(c + 1) : 32'(PERS_NONE), 32'(hd_personality));
      if (c < 2) chk("cap", c ? 32'(CAP_EXTENDED_TENTHS) : 32'(CAP_NORMAL_TENTHS), 32'(hd_capacity));
    end
    for (int c = 0; c < 6; c++) begin
      sel_class <= 3'(c);
      repeat (8) @(posedge pclk);
      chk("fd dec", 32'({c < 2, c >= 2, c % 2 == 0, c >= 4}),
          32'({fd_format, fd_set_density, fd_double, fd_scan}));
    end
    $display("test misc done");
  endtask

  task results;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, bus_init, fd_protect_sw, hd_protect_sw} = 7'h0;
    {fd_media_wp, fd_head_loaded, hd_drive_fault, hd_access} = 4'h0;
    {paddr, pwdata, sel_mode, sel_class, fail_at} = '0;
    {error_cnt, checks, cyc} = 96'h0;
    t_fail();
    t_power();
    t_pins();
    t_err();
    t_misc();
    results();
  end
endmodule
`default_nettype wire
